// File: fbo_pkg.sv
// Shared constants for the flash buffer operations and status read block
package fbo_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_XFER_B1 = 8'h53;
    localparam logic [7:0] OP_XFER_B2 = 8'h55;
    localparam logic [7:0] OP_COMP_B1 = 8'h60;
    localparam logic [7:0] OP_COMP_B2 = 8'h61;
    localparam logic [7:0] OP_RWR_B1 = 8'h58;
    localparam logic [7:0] OP_RWR_B2 = 8'h59;
    localparam logic [7:0] OP_STATUS = 8'hD7;
    // ------------------------------------------------------------
    // Serial framing and address layout
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    localparam logic [5:0] ADR_LAST_BIT = 6'h1F;
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3F;
    localparam int PAGE_W = 11;
    localparam int STD_PAGE_LSB = 9;
    localparam int BIN_PAGE_LSB = 8;
    // ------------------------------------------------------------
    // First status byte field positions
    // ------------------------------------------------------------
    localparam int ST_READY_BIT = 7;
    localparam int ST_COMP_BIT = 6;
    localparam int ST_PROT_BIT = 1;
    localparam int ST_PSIZE_BIT = 0;
    localparam logic [3:0] DENSITY_CODE = 4'h5; // Arbitrary value, not a real part code
    localparam logic [2:0] BIT_TOP = 3'h7;
    // ------------------------------------------------------------
    // Timing: times in ns, counts in 100 MHz cycles (round down)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PAGE_TRANSFER_TIME_NS = 200000;
    localparam int PAGE_COMPARE_TIME_NS = 200000;
    localparam int PAGE_REWRITE_TIME_NS = 4000000;
    localparam int XFER_CYC = PAGE_TRANSFER_TIME_NS / CLK_PERIOD_NS;
    localparam int COMP_CYC = PAGE_COMPARE_TIME_NS / CLK_PERIOD_NS;
    localparam int RWR_CYC = PAGE_REWRITE_TIME_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Array operation kinds and engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_XFER = 2'h0,
        KIND_COMP = 2'h1,
        KIND_RWR_LOAD = 2'h2,
        KIND_RWR_PROG = 2'h3
    } fbo_kind_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_XFER = 3'h1,
        ST_COMP = 3'h3,
        ST_RWR_LOAD = 3'h2,
        ST_RWR_PROG = 3'h6
    } fbo_state_t;
endpackage

// File: fbo_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module fbo_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_q; // First stage, read only by second
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // Next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Register both stages; pins idle high
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= '1;
            sync_out <= '1;
        end else begin
            meta_q <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule
`default_nettype wire

// File: fbo_top.sv
// Serial flash buffer transfer, compare, page rewrite and status read
// Function
// - Transfer opcodes 53h and 55h, three address bytes
// - Standard size: 4 dummy, 11 page, 9 dummy
// - Binary size: 5 dummy, 11 page, 8 dummy
// - Shift while select low; start on select rise
// - Report busy during page transfer
// - Compare opcodes 60h and 61h, same address
// - Compare busy, then bit 6 mismatch result
// - Rewrite opcodes 58h and 59h with address
// - Rewrite loads buffer then programs page back
// - Data after rewrite address means read-modify-write
// - Opcode D7h streams status on every clock
// - Status bytes repeat while select stays low
// - Status resampled per bit; ready in both
// - Status read accepted at any time
// - Select rise ends read, output released
// - Bit 7: 0 busy, 1 ready
// - Bit 1: sector protection enabled
// - Bit 0: 0 standard page, 1 binary page
`timescale 1ns/10ps
`default_nettype none
module fbo_top
    import fbo_pkg::*;
#(
    parameter int XFER_CYCLES = fbo_pkg::XFER_CYC,
    parameter int COMP_CYCLES = fbo_pkg::COMP_CYC,
    parameter int RWR_CYCLES = fbo_pkg::RWR_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic cs_n_pin, // Chip select, active low
    input wire logic sck_pin, // Serial clock, mode 0 or 3
    input wire logic si_pin, // Serial data in
    output logic so_out, // Serial data out
    output logic so_oe, // Serial out enable
    input wire logic protect_en, // Sector protection state
    input wire logic page_bin, // 1 = binary page size
    input wire logic array_mismatch, // Compare result from array
    output logic arr_start, // One-cycle array op start
    output fbo_pkg::fbo_kind_t arr_kind, // Array op kind
    output logic arr_buffer, // 0 = first buffer
    output logic [fbo_pkg::PAGE_W-1:0] arr_page, // Page index
    output logic arr_rmw, // Rewrite with data bytes
    output logic busy // Internal operation running
);
    import fbo_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [2:0] pins_s; // Synchronised cs_n, sck, si
    logic cs_s, sck_s, si_s;
    logic cs_p_q, sck_p_q; // Previous synchronised levels
    logic cs_p_d, sck_p_d;
    logic sck_rise, sck_fall, cs_rise;

    fbo_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({cs_n_pin, sck_pin, si_pin}),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];
    assign sck_rise = !cs_s && sck_s && !sck_p_q;
    assign sck_fall = !cs_s && !sck_s && sck_p_q;
    assign cs_rise = cs_s && !cs_p_q;

    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    logic [5:0] bit_cnt_q, bit_cnt_d; // Bits taken this frame
    logic [31:0] shreg_q, shreg_d; // Opcode and address shifter
    logic [7:0] opcode_q, opcode_d; // Captured opcode
    logic [23:0] addr_q, addr_d; // Captured address bytes
    logic fmt_bin_q, fmt_bin_d; // Page format at command time
    logic data_seen_q, data_seen_d; // Bytes after the address
    logic stat_mode_q, stat_mode_d; // Status stream active
    logic [2:0] st_idx_q, st_idx_d; // Next status bit index
    logic st_second_q, st_second_d; // Second byte in progress
    logic comp_q, comp_d; // Last compare result
    logic so_d, so_oe_d;
    logic [7:0] status_first_byte; // Live first status byte
    logic [7:0] status_second_byte; // Live second status byte
    logic [7:0] cur_byte;

    // Live status, sampled again at every bit
    always_comb begin
        status_first_byte = {busy ? 1'b0 : 1'b1, 1'b0, DENSITY_CODE, 2'b00};
        status_first_byte[ST_COMP_BIT] = comp_q;
        status_first_byte[ST_PROT_BIT] = protect_en;
        status_first_byte[ST_PSIZE_BIT] = page_bin;
        status_second_byte = 8'h00;
        status_second_byte[ST_READY_BIT] = !busy;
        cur_byte = st_second_q ? status_second_byte : status_first_byte;
    end

    // Next-state of the shifter and status streamer
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shreg_d = shreg_q;
        opcode_d = opcode_q;
        addr_d = addr_q;
        fmt_bin_d = fmt_bin_q;
        data_seen_d = data_seen_q;
        stat_mode_d = stat_mode_q;
        st_idx_d = st_idx_q;
        st_second_d = st_second_q;
        so_d = so_out;
        so_oe_d = so_oe;
        cs_p_d = cs_s;
        sck_p_d = sck_s;
        if (cs_s) begin
            // Select high: frame over, output released
            bit_cnt_d = 6'h00;
            data_seen_d = 1'b0;
            stat_mode_d = 1'b0;
            so_oe_d = 1'b0;
        end else begin
            if (sck_rise) begin
                // Sample on rising edge while select low
                shreg_d = {shreg_q[30:0], si_s};
                if (bit_cnt_q != CNT_MAX) begin
                    bit_cnt_d = bit_cnt_q + 6'h01;
                end
                if (bit_cnt_q == OPC_LAST_BIT) begin
                    opcode_d = {shreg_q[6:0], si_s};
                    fmt_bin_d = page_bin;
                    if ({shreg_q[6:0], si_s} == OP_STATUS) begin
                        stat_mode_d = 1'b1;
                        st_idx_d = BIT_TOP;
                        st_second_d = 1'b0;
                    end
                end
                if (bit_cnt_q == ADR_LAST_BIT) begin
                    addr_d = {shreg_q[22:0], si_s};
                end
                if (bit_cnt_q >= CMD_BITS) begin
                    data_seen_d = 1'b1;
                end
            end
            if (sck_fall && stat_mode_q) begin
                // Drive next status bit on falling edge
                so_d = cur_byte[st_idx_q];
                so_oe_d = 1'b1;
                st_idx_d = st_idx_q - 3'h1;
                if (st_idx_q == 3'h0) begin
                    st_second_d = !st_second_q;
                end
            end
        end
    end

    // Register the front end
    always_ff @(posedge clock) begin
        if (reset) begin
            bit_cnt_q <= 6'h00;
            shreg_q <= 32'h0000_0000;
            opcode_q <= 8'h00;
            addr_q <= 24'h00_0000;
            fmt_bin_q <= 1'b0;
            data_seen_q <= 1'b0;
            stat_mode_q <= 1'b0;
            st_idx_q <= 3'h7;
            st_second_q <= 1'b0;
            so_out <= 1'b0;
            so_oe <= 1'b0;
            cs_p_q <= 1'b1;
            sck_p_q <= 1'b1;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shreg_q <= shreg_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            fmt_bin_q <= fmt_bin_d;
            data_seen_q <= data_seen_d;
            stat_mode_q <= stat_mode_d;
            st_idx_q <= st_idx_d;
            st_second_q <= st_second_d;
            so_out <= so_d;
            so_oe <= so_oe_d;
            cs_p_q <= cs_p_d;
            sck_p_q <= sck_p_d;
        end
    end

    // ------------------------------------------------------------
    // Operation engine
    // ------------------------------------------------------------
    fbo_state_t state_q, state_d; // Engine state
    logic [31:0] timer_q, timer_d; // Cycles left in phase
    logic arr_start_d, arr_buffer_d, arr_rmw_d, busy_d;
    fbo_kind_t arr_kind_d;
    logic [PAGE_W-1:0] arr_page_d;
    logic [PAGE_W-1:0] page_idx; // Decoded page index
    logic cmd_whole; // Opcode plus three address bytes

    // Page index per latched format
    always_comb begin
        if (fmt_bin_q) begin
            page_idx = addr_q[BIN_PAGE_LSB +: PAGE_W];
        end else begin
            page_idx = addr_q[STD_PAGE_LSB +: PAGE_W];
        end
        cmd_whole = bit_cnt_q >= CMD_BITS;
    end

    // Engine next values
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        comp_d = comp_q;
        arr_start_d = 1'b0;
        arr_kind_d = arr_kind;
        arr_buffer_d = arr_buffer;
        arr_page_d = arr_page;
        arr_rmw_d = arr_rmw;
        unique case (state_q)
            ST_IDLE: begin
                // Start only on select rise with a whole command
                if (cs_rise && cmd_whole && !stat_mode_q) begin
                    arr_page_d = page_idx;
                    arr_buffer_d = opcode_q[0] ^ (opcode_q == OP_XFER_B2);
                    arr_rmw_d = 1'b0;
                    unique case (opcode_q)
                        OP_XFER_B1, OP_XFER_B2: begin
                            arr_buffer_d = opcode_q == OP_XFER_B2;
                            arr_kind_d = KIND_XFER;
                            arr_start_d = 1'b1;
                            timer_d = 32'(XFER_CYCLES - 1);
                            state_d = ST_XFER;
                        end
                        OP_COMP_B1, OP_COMP_B2: begin
                            arr_buffer_d = opcode_q == OP_COMP_B2;
                            arr_kind_d = KIND_COMP;
                            arr_start_d = 1'b1;
                            timer_d = 32'(COMP_CYCLES - 1);
                            state_d = ST_COMP;
                        end
                        OP_RWR_B1, OP_RWR_B2: begin
                            arr_buffer_d = opcode_q == OP_RWR_B2;
                            arr_kind_d = KIND_RWR_LOAD;
                            arr_rmw_d = data_seen_q;
                            arr_start_d = 1'b1;
                            timer_d = 32'(XFER_CYCLES - 1);
                            state_d = ST_RWR_LOAD;
                        end
                        default: begin
                            // Other opcodes belong to other blocks
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                // Page to buffer copy in progress
                timer_d = timer_q - 32'd1;
                if (timer_q == 32'd0) begin
                    state_d = ST_IDLE;
                end
            end
            ST_COMP: begin
                // Compare in progress; result lands at the end
                timer_d = timer_q - 32'd1;
                if (timer_q == 32'd0) begin
                    comp_d = array_mismatch;
                    state_d = ST_IDLE;
                end
            end
            ST_RWR_LOAD: begin
                // Load phase, then program the same page back
                timer_d = timer_q - 32'd1;
                if (timer_q == 32'd0) begin
                    arr_kind_d = KIND_RWR_PROG;
                    arr_start_d = 1'b1;
                    timer_d = 32'(RWR_CYCLES - 1);
                    state_d = ST_RWR_PROG;
                end
            end
            ST_RWR_PROG: begin
                // Program phase
                timer_d = timer_q - 32'd1;
                if (timer_q == 32'd0) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // Illegal code recovers to idle
                state_d = ST_IDLE;
            end
        endcase
        busy_d = state_d != ST_IDLE;
    end

    // Register the engine
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h0000_0000;
            comp_q <= 1'b0;
            arr_start <= 1'b0;
            arr_kind <= KIND_XFER;
            arr_buffer <= 1'b0;
            arr_page <= '0;
            arr_rmw <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            comp_q <= comp_d;
            arr_start <= arr_start_d;
            arr_kind <= arr_kind_d;
            arr_buffer <= arr_buffer_d;
            arr_page <= arr_page_d;
            arr_rmw <= arr_rmw_d;
            busy <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    busy_on_start_a: assert property (arr_start && arr_kind != KIND_RWR_PROG |-> busy)
        else $error("busy not set at op start");
    start_needs_rise_a: assert property (arr_start && arr_kind != KIND_RWR_PROG |-> $past(cs_rise))
        else $error("op started without select rise");
    comp_result_a: assert property (state_q == ST_COMP && timer_q == 32'd0 ##1 1'b1
        |-> comp_q == $past(array_mismatch))
        else $error("compare result not stored");
    rwr_two_phase_a: assert property (state_q == ST_RWR_LOAD && timer_q == 32'd0
        |=> arr_start && arr_kind == KIND_RWR_PROG && busy)
        else $error("rewrite program phase missing");
    so_release_a: assert property (cs_s |=> !so_oe)
        else $error("output not released after select rise");
    ready_bit_a: assert property (status_first_byte[ST_READY_BIT] == !busy)
        else $error("ready bit wrong");
    psize_bit_a: assert property (status_first_byte[ST_PSIZE_BIT] == page_bin)
        else $error("page size bit wrong");
    byte_wrap_a: assert property (sck_fall && stat_mode_q && st_idx_q == 3'h0
        |=> st_second_q != $past(st_second_q) && st_idx_q == BIT_TOP)
        else $error("status byte did not wrap");
    std_page_a: assert property (arr_start && !$past(fmt_bin_q) && arr_kind != KIND_RWR_PROG
        |-> arr_page == $past(addr_q[STD_PAGE_LSB +: PAGE_W]))
        else $error("standard page index wrong");

    xfer_cov_c: cover property (state_q == ST_XFER ##1 state_q == ST_IDLE);
    comp_cov_c: cover property (state_q == ST_COMP && timer_q == 32'd0);
    rwr_cov_c: cover property (state_q == ST_RWR_PROG);
    stat_cov_c: cover property (stat_mode_q && st_second_q && busy);
endmodule
`default_nettype wire

// File: fbo_host_model.sv
// SPI host model: command frames and status polling, mode 0
`timescale 1ns/10ps
`default_nettype none
module fbo_host_model
    import fbo_pkg::*;
(
    input wire logic clock,
    input wire logic so_out,
    input wire logic so_oe,
    output logic cs_n_pin,
    output logic sck_pin,
    output logic si_pin
);
    localparam int HALF = 4; // Half of the 80 ns link period
    // Idle: deselected, link clock parked low
    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
    end
    // Wait n clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Shift n bits MSB first; data moves while the link clock is low
    task automatic shift(input logic [39:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            si_pin = bits[39-i];
            tick(HALF);
            sck_pin = 1'b1;
            tick(HALF);
            sck_pin = 1'b0;
        end
    endtask
    // End a frame; idle data line must not keep its last value
    task automatic deselect();
        tick(HALF);
        cs_n_pin = 1'b1;
        si_pin = ~si_pin;
        // Hand back early so the one-cycle start pulse is still ahead
        tick(1);
    endtask
    // One command frame of n bits from the top of bits
    task automatic frame(input logic [39:0] bits, input int n);
        cs_n_pin = 1'b0;
        tick(HALF);
        shift(bits, n);
        deselect();
    endtask
    // Status read of n bits, each sampled one clock after the rise
    task automatic status(input int n, output logic [143:0] rx, output logic oe_ok);
        rx = '0;
        oe_ok = 1'b1;
        cs_n_pin = 1'b0;
        tick(HALF);
        shift({OP_STATUS, 32'h0}, 8);
        for (int i = 0; i < n; i++) begin
            tick(HALF);
            sck_pin = 1'b1;
            tick(1);
            // A released line reads as the inverse of its last value
            rx[143-i] = so_oe ? so_out : ~so_out;
            oe_ok = oe_ok & (so_oe === 1'b1);
            tick(HALF - 1);
            sck_pin = 1'b0;
        end
        deselect();
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the buffer operations and status read block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fbo_pkg::*;
    localparam int XC = 400; // Shortened transfer time
    localparam int CC = 400; // Shortened compare time
    localparam int RC = 600; // Shortened program time
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic protect_en, page_bin, array_mismatch, comp_exp;
    logic cs_n, sck, si, so_out, so_oe, arr_start, arr_buffer, arr_rmw, busy;
    fbo_kind_t arr_kind;
    logic [PAGE_W-1:0] arr_page;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] ops [7] = '{OP_XFER_B1, OP_XFER_B2, OP_COMP_B1, OP_COMP_B2,
        OP_RWR_B1, OP_RWR_B2, OP_RWR_B1};
    fbo_kind_t kinds [7] = '{KIND_XFER, KIND_XFER, KIND_COMP, KIND_COMP,
        KIND_RWR_LOAD, KIND_RWR_LOAD, KIND_RWR_LOAD};
    always #5 clock = ~clock;
    fbo_top #(.XFER_CYCLES(XC), .COMP_CYCLES(CC), .RWR_CYCLES(RC)) i_fbo_top (
        .clock(clock), .reset(reset), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
        .so_out(so_out), .so_oe(so_oe), .protect_en(protect_en), .page_bin(page_bin),
        .array_mismatch(array_mismatch), .arr_start(arr_start), .arr_kind(arr_kind),
        .arr_buffer(arr_buffer), .arr_page(arr_page), .arr_rmw(arr_rmw), .busy(busy));
    fbo_host_model i_fbo_host_model (
        .clock(clock), .so_out(so_out), .so_oe(so_oe),
        .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic print_verdict();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Wait for an array phase start, check its fields, then busy
    task automatic wait_start(input fbo_kind_t kind, input logic bsel,
        input logic [10:0] page, input int lim);
        int k;
        k = 0;
        while (arr_start !== 1'b1 && k < lim) begin
            @(posedge clock);
            #1;
            k++;
        end
        check(16'(arr_start), 16'h1);
        check(16'(arr_kind), 16'(kind));
        check(16'(arr_buffer), 16'(bsel));
        check(16'(arr_page), 16'(page));
        @(posedge clock);
        #1;
        check(16'(busy), 16'h1);
    endtask
    // Output must be released shortly after deselect
    task automatic release_check();
        int k;
        k = 0;
        while (so_oe !== 1'b0 && k < 10) begin
            @(posedge clock);
            #1;
            k++;
        end
        check(16'(so_oe), 16'h0);
    endtask
    // One array command, then a long status poll across its end
    task automatic run_op(input int i);
        logic [23:0] adr;
        logic [10:0] pg;
        logic [143:0] rx;
        logic oe_ok;
        adr = 24'($urandom);
        pg = page_bin ? adr[18:8] : adr[19:9];
        array_mismatch = 1'($urandom);
        i_fbo_host_model.frame({ops[i], adr, 8'($urandom)}, (i == 6) ? 40 : 32);
        page_bin = 1'($urandom);
        protect_en = 1'($urandom);
        if (kinds[i] == KIND_COMP) comp_exp = array_mismatch;
        wait_start(kinds[i], 1'(i % 2), pg, 12);
        if (kinds[i] == KIND_RWR_LOAD) check(16'(arr_rmw), 16'(i == 6));
        fork
            i_fbo_host_model.status(144, rx, oe_ok);
            if (kinds[i] == KIND_RWR_LOAD) wait_start(KIND_RWR_PROG, 1'(i % 2), pg, XC + 20);
        join
        for (int b = 0; b < 18; b++) begin
            if (b % 2 == 0) check(16'(rx[136-8*b +: 6]), 16'({DENSITY_CODE, protect_en, page_bin}));
            else check(16'(rx[136-8*b +: 7]), 16'h0);
        end
        check(16'({rx[143], rx[135]}), 16'h0);
        check(16'({rx[15], rx[7]}), 16'h3);
        check(16'(rx[14]), 16'(comp_exp));
        check(16'(oe_ok), 16'h1);
        check(16'(busy), 16'h0);
        release_check();
    endtask
    // Main sequence
    initial begin
        logic [143:0] rx;
        logic oe_ok;
        logic seen;
        void'($urandom(32'hC33C));
        protect_en = 1'b0;
        page_bin = 1'b0;
        array_mismatch = 1'b0;
        comp_exp = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        reset = 1'b0;
        check(16'({so_oe, busy, arr_start}), 16'h0);
        repeat (4) @(posedge clock);
        #1;
        for (int i = 0; i < 7; i++) run_op(i);
        // Short frame and unknown opcode start nothing
        for (int j = 0; j < 2; j++) begin
            i_fbo_host_model.frame({(j == 1) ? 8'hA5 : OP_XFER_B1, 32'h0}, (j == 1) ? 32 : 16);
            seen = 1'b0;
            repeat (12) begin
                @(posedge clock);
                #1;
                seen = seen | arr_start | busy;
            end
            check(16'(seen), 16'h0);
        end
        // Idle poll ended mid-byte
        i_fbo_host_model.status(13, rx, oe_ok);
        check(16'(rx[143:136]), 16'({1'b1, comp_exp, DENSITY_CODE, protect_en, page_bin}));
        check(16'(oe_ok), 16'h1);
        release_check();
        print_verdict();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
